// File: dv/lcd_row_scan_shift_driver_bench.sv
// lcd_row_scan_shift_driver_bench: self-checking bench of lrsd_top.
// assumes lrsd_panel_ctrl drives strobe, data and blank; apb driven here.
`timescale 1ns/1ps
`default_nettype none
module lcd_row_scan_shift_driver_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, feed_on;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic direction_select, mode_select, polarity_alternate_in, shift_strobe;
   logic output_blank_n, second_half_data_in, a_drive, b_drive;
   logic edge_a_data_in, edge_a_data_out, edge_a_data_oe;
   logic edge_b_data_in, edge_b_data_out, edge_b_data_oe;
   logic [199:0] row_drive_outputs;
   logic exp_q [1:100];
   int errors, cmp_count;
   always #2 pclk = ~pclk;
   // the shared pin carries whichever side has its enable up
   assign edge_a_data_in = edge_a_data_oe ? edge_a_data_out : a_drive;
   assign edge_b_data_in = edge_b_data_oe ? edge_b_data_out : b_drive;
   lrsd_top i_lrsd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .shift_strobe(shift_strobe), .direction_select(direction_select),
      .mode_select(mode_select), .polarity_alternate_in(polarity_alternate_in),
      .output_blank_n(output_blank_n), .second_half_data_in(second_half_data_in),
      .factory_sel_a(1'b0), .factory_sel_b(1'b0), .edge_a_data_in(edge_a_data_in),
      .edge_a_data_out(edge_a_data_out), .edge_a_data_oe(edge_a_data_oe),
      .edge_b_data_in(edge_b_data_in), .edge_b_data_out(edge_b_data_out),
      .edge_b_data_oe(edge_b_data_oe), .row_drive_outputs(row_drive_outputs));
   lrsd_panel_ctrl i_lrsd_panel_ctrl (.pclk(pclk), .shift_strobe(shift_strobe),
      .a_drive(a_drive), .b_drive(b_drive), .second_half_data_in(second_half_data_in),
      .output_blank_n(output_blank_n));
   task automatic complete_run();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      output logic [31:0] data, output logic slverr);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      data = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         complete_run();
      end
      @(posedge pclk);
   endtask : apb
   task automatic clear_model();
      for (int n = 1; n <= 100; n++) begin
         exp_q[n] = 1'b0;
      end
   endtask : clear_model
   task automatic check_rows();
      logic [1:0] want;
      for (int n = 1; n <= 100; n++) begin
         if (polarity_alternate_in) begin
            want = exp_q[n] ? lrsd_pkg::LVL_V0 : lrsd_pkg::LVL_V4;
         end else begin
            want = exp_q[n] ? lrsd_pkg::LVL_V5 : lrsd_pkg::LVL_V1;
         end
         check($sformatf("row %0d", n), {30'h0, want}, {30'h0, row_drive_outputs[2*n-2 +: 2]});
      end
   endtask : check_rows
   // model moves first; with buffer feed on, pins carry the inverse to prove they are ignored
   task automatic do_shift(input logic a, input logic b, input logic d);
      logic tail;
      tail = direction_select ? exp_q[1] : exp_q[100];
      if (!direction_select) begin
         for (int i = 100; i > 1; i--) begin
            exp_q[i] = (mode_select && i == 51) ? d : exp_q[i-1];
         end
         exp_q[1] = a;
      end else begin
         for (int i = 1; i < 100; i++) begin
            exp_q[i] = (mode_select && i == 50) ? d : exp_q[i+1];
         end
         exp_q[100] = b;
      end
      i_lrsd_panel_ctrl.shift(a ^ feed_on, b ^ feed_on, d ^ feed_on);
      check("cascade", {31'h0, tail}, {31'h0, direction_select ? edge_a_data_out : edge_b_data_out});
   endtask : do_shift
   task automatic set_pins(input logic dir, input logic mode, input logic pol);
      direction_select <= dir;
      mode_select <= mode;
      polarity_alternate_in <= pol;
      repeat (6) @(posedge pclk);
   endtask : set_pins
   task automatic scen_apb();
      apb(1'b0, 12'h100, 32'h0, rd, err);
      check("unmapped rd err", 32'h1, {31'h0, err});
      check("unmapped rd data", 32'h0, rd);
      apb(1'b1, 12'h100, 32'hFFFF_FFFF, rd, err);
      check("unmapped wr err", 32'h1, {31'h0, err});
      apb(1'b0, lrsd_pkg::OFS_COUNT, 32'h0, rd, err);
      check("count reset", {16'h0, lrsd_pkg::COUNT_RST}, rd);
      apb(1'b1, lrsd_pkg::OFS_CTRL, 32'h1, rd, err);
      apb(1'b0, lrsd_pkg::OFS_CTRL, 32'h0, rd, err);
      check("ctrl", 32'h1, rd);
      apb(1'b1, lrsd_pkg::OFS_CTRL, lrsd_pkg::CTRL_RST, rd, err);
   endtask : scen_apb
   // all four direction and mode pairs, both polarities
   task automatic scen_dirs();
      for (int k = 0; k < 4; k++) begin
         set_pins(k[0], k[1], k[0] ^ k[1]);
         check("oe b", {31'h0, ~k[0]}, {31'h0, edge_b_data_oe});
         check("oe a", {31'h0, k[0]}, {31'h0, edge_a_data_oe});
         for (int i = 0; i < 100; i++) begin
            do_shift(i % 3 == 0, i % 7 < 3, i % 5 == 1);
         end
         check_rows();
      end
   endtask : scen_dirs
   task automatic scen_blank();
      i_lrsd_panel_ctrl.set_blank(1'b0);
      #1;
      check("rows async", 32'h1, {31'h0, row_drive_outputs === '0});
      repeat (4) @(posedge pclk);
      i_lrsd_panel_ctrl.shift(1'b1, 1'b1, 1'b1);
      check("rows blanked", 32'h1, {31'h0, row_drive_outputs === '0});
      check("cascade cleared", 32'h0, {30'h0, edge_a_data_out, edge_b_data_out});
      i_lrsd_panel_ctrl.set_blank(1'b1);
      repeat (5) @(posedge pclk);
      clear_model();
      check_rows();
      do_shift(1'b1, 1'b1, 1'b1);
      check_rows();
      apb(1'b0, lrsd_pkg::OFS_ROWS1, 32'h0, rd, err);
      check("rows1 word", 32'h0002_0000, rd);
      apb(1'b0, lrsd_pkg::OFS_ROWS3, 32'h0, rd, err);
      check("rows3 word", 32'h0000_0008, rd);
      apb(1'b0, lrsd_pkg::OFS_COUNT, 32'h0, rd, err);
      check("count skips blank", 32'h0000_0191, rd);
      apb(1'b0, lrsd_pkg::OFS_STATUS, 32'h0, rd, err);
      check("status pins", 32'h0000_0019, rd);
   endtask : scen_blank
   // buffer filled until full, drained by strobes, then a strobe on empty stalls
   task automatic scen_feed();
      logic [1:0] v;
      set_pins(1'b1, 1'b1, 1'b1);
      apb(1'b1, lrsd_pkg::OFS_COUNT, 32'h0, rd, err);
      apb(1'b1, lrsd_pkg::OFS_CTRL, 32'h1, rd, err);
      for (int k = 0; k < 16; k++) begin
         v = {k[1], k[0] ^ k[2]};
         apb(1'b1, lrsd_pkg::OFS_FEED, {30'h0, v}, rd, err);
      end
      apb(1'b0, lrsd_pkg::OFS_STATUS, 32'h0, rd, err);
      check("full", 32'h1, {31'h0, rd[lrsd_pkg::ST_FULL]});
      feed_on = 1'b1;
      for (int k = 0; k < 16; k++) begin
         v = {k[1], k[0] ^ k[2]};
         do_shift(v[0], v[0], v[1]);
      end
      apb(1'b0, lrsd_pkg::OFS_STATUS, 32'h0, rd, err);
      check("empty", 32'h1, {31'h0, rd[lrsd_pkg::ST_EMPTY]});
      i_lrsd_panel_ctrl.shift(1'b1, 1'b1, 1'b1);
      check_rows();
      apb(1'b0, lrsd_pkg::OFS_STATUS, 32'h0, rd, err);
      check("stall", 32'h1, {31'h0, rd[lrsd_pkg::ST_STALL]});
      apb(1'b1, lrsd_pkg::OFS_STATUS, 32'h0000_0040, rd, err);
      apb(1'b0, lrsd_pkg::OFS_STATUS, 32'h0, rd, err);
      check("stall cleared", 32'h0, {31'h0, rd[lrsd_pkg::ST_STALL]});
      apb(1'b0, lrsd_pkg::OFS_COUNT, 32'h0, rd, err);
      check("count", 32'h10, rd);
      apb(1'b1, lrsd_pkg::OFS_CTRL, 32'h0, rd, err);
      feed_on = 1'b0;
   endtask : scen_feed
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      direction_select = 1'b0;
      mode_select = 1'b0;
      polarity_alternate_in = 1'b0;
      feed_on = 1'b0;
      clear_model();
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      scen_apb();
      scen_dirs();
      scen_blank();
      scen_feed();
      complete_run();
   end
endmodule : lcd_row_scan_shift_driver_bench
`default_nettype wire

// File: dv/lrsd_panel_ctrl.sv
// lrsd_panel_ctrl: model of the panel controller driving strobe, data and blank.
// assumes tasks are entered just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module lrsd_panel_ctrl (
   input wire logic pclk,
   output logic shift_strobe,
   output logic a_drive,
   output logic b_drive,
   output logic second_half_data_in,
   output logic output_blank_n
);
   initial begin
      shift_strobe = 1'b1;
      a_drive = 1'b0;
      b_drive = 1'b0;
      second_half_data_in = 1'b0;
      output_blank_n = 1'b1;
   end
   // data settles two cycles before the fall and is held after it, never floating
   task automatic shift(input logic a, input logic b, input logic d);
      @(posedge pclk);
      a_drive <= a;
      b_drive <= b;
      second_half_data_in <= d;
      repeat (2) @(posedge pclk);
      shift_strobe <= 1'b0;
      repeat (4) @(posedge pclk);
      shift_strobe <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask : shift
   // caller keeps 4 pclk after release before the next strobe fall
   task automatic set_blank(input logic v);
      @(posedge pclk);
      output_blank_n <= v;
   endtask : set_blank
endmodule : lrsd_panel_ctrl
`default_nettype wire

// File: dv/lrsd_top_sva.sv
// lrsd_top_sva: port checks of the row scan driver.
// assumes pins hold each level >=3 pclk and blank release keeps 4 pclk clear.
`timescale 1ns/1ps
`default_nettype none
module lrsd_top_sva #(
   parameter int ROWS = 100
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic shift_strobe,
   input wire logic direction_select,
   input wire logic mode_select,
   input wire logic polarity_alternate_in,
   input wire logic output_blank_n,
   input wire logic edge_a_data_out,
   input wire logic edge_a_data_oe,
   input wire logic edge_b_data_out,
   input wire logic edge_b_data_oe,
   input wire logic [lrsd_pkg::LVL_W*ROWS-1:0] row_drive_outputs
);
   logic [ROWS-1:0] lo_bits;
   logic [ROWS-1:0] hi_bits;
   logic tail_bit;
   always_comb begin
      for (int i = 0; i < ROWS; i++) begin
         lo_bits[i] = row_drive_outputs[2*i];
         hi_bits[i] = row_drive_outputs[2*i+1];
      end
   end
   // last row bit recovered from its level code
   assign tail_bit = row_drive_outputs[2*ROWS-1] ^ polarity_alternate_in;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_blank_rows_v0: assert property (!output_blank_n |-> row_drive_outputs == '0)
      else $error("rows not at v0 while blanked");
   a_blank_out_zero: assert property (!output_blank_n |-> !edge_a_data_out && !edge_b_data_out)
      else $error("cascade out not cleared while blanked");
   a_oe_right_dir: assert property (!direction_select [*5] |-> edge_b_data_oe && !edge_a_data_oe)
      else $error("edge b not driving on right shift");
   a_oe_left_dir: assert property (direction_select [*5] |-> edge_a_data_oe && !edge_b_data_oe)
      else $error("edge a not driving on left shift");
   a_pol_select: assert property ((output_blank_n && $stable(polarity_alternate_in)) [*5]
      |-> lo_bits == {ROWS{!polarity_alternate_in}}) else $error("row code wrong for polarity");
   a_release_deselect: assert property ($rose(output_blank_n) |-> ##3
      hi_bits == {ROWS{polarity_alternate_in}} && lo_bits == {ROWS{!polarity_alternate_in}})
      else $error("no deselect level");
   a_rows_quiet: assert property ((shift_strobe && output_blank_n
      && $stable(polarity_alternate_in)) [*6] |=> $stable(row_drive_outputs))
      else $error("rows moved without a strobe edge");
   a_cascade_right: assert property ($fell(shift_strobe) && output_blank_n && !direction_select
      |-> ##3 edge_b_data_out == $past(tail_bit, 3)) else $error("cascade out wrong");
   c_dual_shift: cover property ($fell(shift_strobe) && mode_select);
   c_left_shift: cover property ($fell(shift_strobe) && direction_select);
   c_blank_release: cover property ($rose(output_blank_n));
endmodule : lrsd_top_sva
bind lrsd_top lrsd_top_sva #(.ROWS(ROWS)) i_lrsd_top_sva (.pclk(pclk), .presetn(presetn),
   .shift_strobe(shift_strobe), .direction_select(direction_select), .mode_select(mode_select),
   .polarity_alternate_in(polarity_alternate_in), .output_blank_n(output_blank_n),
   .edge_a_data_out(edge_a_data_out), .edge_a_data_oe(edge_a_data_oe),
   .edge_b_data_out(edge_b_data_out), .edge_b_data_oe(edge_b_data_oe),
   .row_drive_outputs(row_drive_outputs));
`default_nettype wire

// File: rtl/lrsd_fifo.sv
// lrsd_fifo: small first-word-fall-through buffer with registered read data.
// assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module lrsd_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;
   logic [AW-1:0] rd_nxt;
   logic [AW:0] count_nxt;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign rd_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
   assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge pclk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         rd_ptr_r <= rd_nxt;
         count_r <= count_nxt;
         in_ready <= count_nxt < (AW+1)'(DEPTH);
         out_valid <= count_nxt != '0;
         // bypass keeps the head honest when the slot is written this cycle
         if (push && wr_ptr_r == rd_nxt) begin
            out_data <= in_data;
         end else begin
            out_data <= mem[rd_nxt];
         end
      end
   end
endmodule : lrsd_fifo
`default_nettype wire

// File: rtl/lrsd_pkg.sv
// lrsd_pkg: shared constants of the row scan shift driver.
// assumes one 250 MHz clock and 32-bit apb data with word-aligned registers.
package lrsd_pkg;
   // register geometry
   localparam int N_ROWS = 100;
   localparam int HALF_ROWS = 50;
   localparam int LVL_W = 2;
   localparam int FIFO_W = 2;
   localparam int FIFO_D = 16;
   localparam int ADDR_W = 12;

   // output level codes, one per row output
   localparam logic [1:0] LVL_V0 = 2'h0;
   localparam logic [1:0] LVL_V1 = 2'h1;
   localparam logic [1:0] LVL_V4 = 2'h2;
   localparam logic [1:0] LVL_V5 = 2'h3;

   // apb register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_FEED = 12'h008;
   localparam logic [11:0] OFS_COUNT = 12'h00C;
   localparam logic [11:0] OFS_ROWS0 = 12'h010;
   localparam logic [11:0] OFS_ROWS1 = 12'h014;
   localparam logic [11:0] OFS_ROWS2 = 12'h018;
   localparam logic [11:0] OFS_ROWS3 = 12'h01C;

   // field positions
   localparam int CTRL_SW_FEED = 0;
   localparam int ST_EMPTY = 0;
   localparam int ST_FULL = 1;
   localparam int ST_BLANK = 2;
   localparam int ST_MODE = 3;
   localparam int ST_DIR = 4;
   localparam int ST_POL = 5;
   localparam int ST_STALL = 6;
   localparam int ST_FSEL_A = 7;
   localparam int ST_FSEL_B = 8;
   localparam int FEED_MAIN = 0;
   localparam int FEED_SECOND = 1;

   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] COUNT_RST = 16'h0000;

   // pin synchroniser index layout
   localparam int PIN_N = 10;
   localparam int P_STROBE = 0;
   localparam int P_DIR = 1;
   localparam int P_MODE = 2;
   localparam int P_POL = 3;
   localparam int P_A_IN = 4;
   localparam int P_B_IN = 5;
   localparam int P_SECOND_HALF_DATA_IN = 6;
   localparam int P_BLANK_N = 7;
   localparam int P_FSEL_A = 8;
   localparam int P_FSEL_B = 9;
endpackage : lrsd_pkg

// File: rtl/lrsd_top.sv
// lrsd_top: 100-row scan shift register with four-level row selection and apb access.
// assumes the panel controller pins are asynchronous to pclk and much slower than it.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lrsd_top #(
   parameter int ROWS = lrsd_pkg::N_ROWS,
   parameter int HALF = lrsd_pkg::HALF_ROWS,
   parameter int FIFO_DEPTH = lrsd_pkg::FIFO_D
) (
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lrsd_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // panel controller pins
   input wire logic shift_strobe,
   input wire logic direction_select,
   input wire logic mode_select,
   input wire logic polarity_alternate_in,
   input wire logic output_blank_n,
   input wire logic second_half_data_in,
   input wire logic factory_sel_a,
   input wire logic factory_sel_b,
   input wire logic edge_a_data_in,
   output logic edge_a_data_out,
   output logic edge_a_data_oe,
   input wire logic edge_b_data_in,
   output logic edge_b_data_out,
   output logic edge_b_data_oe,
   // two level-code bits per row, row n at [2n+1:2n]
   output logic [lrsd_pkg::LVL_W*ROWS-1:0] row_drive_outputs
);
   logic [lrsd_pkg::PIN_N-1:0] pin_raw;
   logic [lrsd_pkg::PIN_N-1:0] pin_s1_r;
   logic [lrsd_pkg::PIN_N-1:0] pin_s2_r;
   logic strobe_prev_r;
   logic strobe_fall;
   logic dir_s;
   logic dual_s;
   logic pol_s;
   logic blank_s;
   logic clr_n;
   logic [ROWS-1:0] shreg_r;
   logic [ROWS-1:0] shreg_nxt;
   logic main_in;
   logic second_in;
   logic shift_go;
   logic feed_miss;
   logic sw_feed_r;
   logic stall_r;
   logic [15:0] count_r;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [lrsd_pkg::FIFO_W-1:0] fifo_out_data;
   logic acc;
   logic commit;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wait_full;
   logic wr_go;

   // row word n of the register, zero-extended above the last row
   function automatic logic [31:0] row_word(input logic [ROWS-1:0] v, input int idx);
      logic [31:0] w;
      w = '0;
      for (int k = 0; k < 32; k++) begin
         if (idx * 32 + k < ROWS) begin
            w[k] = v[idx*32+k];
         end
      end
      return w;
   endfunction : row_word

   // level code for one row from polarity and register bit
   function automatic logic [1:0] level_of(input logic pol, input logic bit_v);
      logic [1:0] l;
      l = lrsd_pkg::LVL_V0;
      case ({pol, bit_v})
         2'h0: l = lrsd_pkg::LVL_V1;
         2'h1: l = lrsd_pkg::LVL_V5;
         2'h2: l = lrsd_pkg::LVL_V4;
         default: l = lrsd_pkg::LVL_V0;
      endcase
      return l;
   endfunction : level_of

   // write strobe for one offset; shared by every writable register
   function automatic logic wr_to(input logic go, input logic [lrsd_pkg::ADDR_W-1:0] a,
                                  input logic [lrsd_pkg::ADDR_W-1:0] ofs);
      return go && a == ofs;
   endfunction : wr_to

   // pins are asynchronous, so every one passes two flops; blank also clears directly through clr_n
   assign pin_raw[lrsd_pkg::P_STROBE] = shift_strobe;
   assign pin_raw[lrsd_pkg::P_DIR] = direction_select;
   assign pin_raw[lrsd_pkg::P_MODE] = mode_select;
   assign pin_raw[lrsd_pkg::P_POL] = polarity_alternate_in;
   assign pin_raw[lrsd_pkg::P_A_IN] = edge_a_data_in;
   assign pin_raw[lrsd_pkg::P_B_IN] = edge_b_data_in;
   assign pin_raw[lrsd_pkg::P_SECOND_HALF_DATA_IN] = second_half_data_in;
   assign pin_raw[lrsd_pkg::P_BLANK_N] = output_blank_n;
   assign pin_raw[lrsd_pkg::P_FSEL_A] = factory_sel_a;
   assign pin_raw[lrsd_pkg::P_FSEL_B] = factory_sel_b;

   // zero after reset, so the strobe detector can only see a real fall
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_prev_r <= 1'b0;
      end else begin
         strobe_prev_r <= pin_s2_r[lrsd_pkg::P_STROBE];
      end
   end

   assign dir_s = pin_s2_r[lrsd_pkg::P_DIR];
   assign dual_s = pin_s2_r[lrsd_pkg::P_MODE];
   assign pol_s = pin_s2_r[lrsd_pkg::P_POL];
   assign blank_s = !pin_s2_r[lrsd_pkg::P_BLANK_N];
   assign strobe_fall = strobe_prev_r && !pin_s2_r[lrsd_pkg::P_STROBE];

   // blank acts as a direct clear; the pin is a level, so its glitches only clear early
   assign clr_n = presetn && output_blank_n;

   // serial sources: pins, or the software feed buffer when enabled
   always_comb begin
      main_in = dir_s ? pin_s2_r[lrsd_pkg::P_B_IN] : pin_s2_r[lrsd_pkg::P_A_IN];
      second_in = pin_s2_r[lrsd_pkg::P_SECOND_HALF_DATA_IN];
      if (sw_feed_r) begin
         main_in = fifo_out_data[lrsd_pkg::FEED_MAIN];
         second_in = fifo_out_data[lrsd_pkg::FEED_SECOND];
      end
   end

   // an edge in feed mode with nothing buffered is skipped, not filled with junk
   assign shift_go = strobe_fall && !blank_s && (!sw_feed_r || fifo_out_valid);
   assign feed_miss = strobe_fall && !blank_s && sw_feed_r && !fifo_out_valid;
   assign fifo_out_ready = sw_feed_r && strobe_fall && !blank_s;

   // next register value for the selected direction and mode
   // in dual mode the middle bit is overwritten, which splits the chain in two
   always_comb begin
      shreg_nxt = shreg_r;
      if (!dir_s) begin
         shreg_nxt = {shreg_r[ROWS-2:0], main_in};
         if (dual_s) begin
            shreg_nxt[HALF] = second_in;
         end
      end else begin
         shreg_nxt = {main_in, shreg_r[ROWS-1:1]};
         if (dual_s) begin
            shreg_nxt[HALF-1] = second_in;
         end
      end
   end

   always_ff @(posedge pclk or negedge clr_n) begin
      if (!clr_n) begin
         shreg_r <= '0;
      end else if (shift_go) begin
         shreg_r <= shreg_nxt;
      end
   end

   // cascade output: the bit pushed out of the far end by the last shift
   always_ff @(posedge pclk or negedge clr_n) begin
      if (!clr_n) begin
         edge_a_data_out <= 1'b0;
         edge_b_data_out <= 1'b0;
      end else if (shift_go) begin
         if (dir_s) begin
            edge_a_data_out <= shreg_r[0];
         end else begin
            edge_b_data_out <= shreg_r[ROWS-1];
         end
      end
   end

   // only the output side of the chain drives its pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_a_data_oe <= 1'b0;
         edge_b_data_oe <= 1'b0;
      end else begin
         edge_a_data_oe <= dir_s;
         edge_b_data_oe <= !dir_s;
      end
   end

   // level selection, one generated stage per row
   // rows lag the register by one edge, with no latch stage in between
   for (genvar g = 0; g < ROWS; g++) begin : g_row
      always_ff @(posedge pclk or negedge clr_n) begin
         if (!clr_n) begin
            row_drive_outputs[2*g+:2] <= lrsd_pkg::LVL_V0;
         end else if (blank_s) begin
            row_drive_outputs[2*g+:2] <= lrsd_pkg::LVL_V0;
         end else begin
            row_drive_outputs[2*g+:2] <= level_of(pol_s, shreg_r[g]);
         end
      end
   end

   // feed buffer between software writes and the serial inputs
   // each entry is two bits: main input and second-half input
   lrsd_fifo #(
      .WIDTH(lrsd_pkg::FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_feed (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(pwdata[lrsd_pkg::FIFO_W-1:0]),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // apb access: answer one cycle into the access phase, or later for a full feed
   assign acc = psel && penable;
   assign commit = acc && pready;
   assign wr_go = commit && pwrite;
   // a full buffer stretches the access phase, so a feed word is never dropped
   assign wait_full = wr_to(pwrite, paddr, lrsd_pkg::OFS_FEED) && !fifo_in_ready;
   assign fifo_in_valid = wr_to(wr_go, paddr, lrsd_pkg::OFS_FEED);

   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      if (paddr == lrsd_pkg::OFS_CTRL) begin
         rd_word[lrsd_pkg::CTRL_SW_FEED] = sw_feed_r;
      end else if (paddr == lrsd_pkg::OFS_STATUS) begin
         rd_word[lrsd_pkg::ST_EMPTY] = !fifo_out_valid;
         rd_word[lrsd_pkg::ST_FULL] = !fifo_in_ready;
         rd_word[lrsd_pkg::ST_BLANK] = blank_s;
         rd_word[lrsd_pkg::ST_MODE] = dual_s;
         rd_word[lrsd_pkg::ST_DIR] = dir_s;
         rd_word[lrsd_pkg::ST_POL] = pol_s;
         rd_word[lrsd_pkg::ST_STALL] = stall_r;
         rd_word[lrsd_pkg::ST_FSEL_A] = pin_s2_r[lrsd_pkg::P_FSEL_A];
         rd_word[lrsd_pkg::ST_FSEL_B] = pin_s2_r[lrsd_pkg::P_FSEL_B];
      end else if (paddr == lrsd_pkg::OFS_FEED) begin
         rd_word = '0;
      end else if (paddr == lrsd_pkg::OFS_COUNT) begin
         rd_word[15:0] = count_r;
      end else if (paddr == lrsd_pkg::OFS_ROWS0) begin
         rd_word = row_word(shreg_r, 0);
      end else if (paddr == lrsd_pkg::OFS_ROWS1) begin
         rd_word = row_word(shreg_r, 1);
      end else if (paddr == lrsd_pkg::OFS_ROWS2) begin
         rd_word = row_word(shreg_r, 2);
      end else if (paddr == lrsd_pkg::OFS_ROWS3) begin
         rd_word = row_word(shreg_r, 3);
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (acc && !pready && !wait_full) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0000_0000 : rd_word;
         pslverr <= !rd_hit;
      end else begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end
   end

   // control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_feed_r <= lrsd_pkg::CTRL_RST[lrsd_pkg::CTRL_SW_FEED];
      end else if (wr_to(wr_go, paddr, lrsd_pkg::OFS_CTRL)) begin
         sw_feed_r <= pwdata[lrsd_pkg::CTRL_SW_FEED];
      end
   end

   // skipped-edge flag: a miss in the clearing cycle still sets it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_r <= 1'b0;
      end else if (feed_miss) begin
         stall_r <= 1'b1;
      end else if (wr_to(wr_go, paddr, lrsd_pkg::OFS_STATUS) && pwdata[lrsd_pkg::ST_STALL]) begin
         stall_r <= 1'b0;
      end
   end

   // accepted shifts, wraps; writing any value zeroes it
   // edges refused while blanked never reach the count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= lrsd_pkg::COUNT_RST;
      end else if (wr_to(wr_go, paddr, lrsd_pkg::OFS_COUNT)) begin
         count_r <= lrsd_pkg::COUNT_RST;
      end else if (shift_go) begin
         count_r <= count_r + 16'h0001;
      end
   end
endmodule : lrsd_top
`default_nettype wire
